// file: pkg/urpt_pkg.sv
// constants, register map and state codes for the synchronous serial channel
package urpt_pkg;
  localparam int ADDR_W = 8;
  localparam int GUARD_W = 8;
  localparam int TOUT_W = 16;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RXH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TXH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GUARD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RTO = 8'h18;
  // control_reg command bits
  localparam int CMD_CLR = 0;
  localparam int CMD_SEND_ADDRESS_CMD = 1;
  localparam int CMD_STWAIT = 2;
  localparam int CMD_RLWAIT = 3;
  // mode_reg fields
  localparam int MODE_SYNC = 0;
  localparam int MODE_PAR_LSB = 1;
  localparam int PAR_W = 3;
  localparam logic [PAR_W-1:0] PAR_EVEN = 3'h0;
  localparam logic [PAR_W-1:0] PAR_ODD = 3'h1;
  localparam logic [PAR_W-1:0] PAR_SPACE = 3'h2;
  localparam logic [PAR_W-1:0] PAR_MARK = 3'h3;
  localparam logic [PAR_W-1:0] PAR_NONE = 3'h4;
  localparam logic [PAR_W-1:0] PAR_MD0 = 3'h6;
  localparam logic [PAR_W-1:0] PAR_MD1 = 3'h7;
  // channel_status_reg bits
  localparam int ST_RX_READY_FLAG = 0;
  localparam int ST_TX_READY_FLAG = 1;
  localparam int ST_TXEMP = 2;
  localparam int ST_OVR = 3;
  localparam int ST_PARITY_ERR_FLAG = 4;
  localparam int ST_TOUT = 5;
  // reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [GUARD_W-1:0] GUARD_RST = 8'h00;
  localparam logic [TOUT_W-1:0] RTO_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PAR = 6'h08, TX_STOP = 6'h10, TX_GUARD = 6'h20
  } urpt_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_DATA = 4'h2, RX_PAR = 4'h4, RX_STOP = 4'h8
  } urpt_rx_e;
endpackage

// file: rtl/urpt_top.sv
// synchronous serial channel: receiver, parity, multi-drop, timeguard, idle time-out
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module urpt_top
  import urpt_pkg::*;
#(
  parameter int DATA_BITS = 8
)(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic BAUD_TICK,
  input wire logic RXD,
  output logic TXD,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  if (DATA_BITS < 5 || DATA_BITS > 8)
  begin : g_chk
    $error("DATA_BITS must lie in 5..8");
  end

  logic [31:0] wmask;
  logic [3:0] mode_r;
  logic [GUARD_W-1:0] guard_r;
  logic [TOUT_W-1:0] rto_r;
  logic rxd_m_r, rxd_s_r;
  logic tick, wr_fire, rd_fire, wr_ok, rd_ok;
  logic [31:0] rd_mux;
  logic clr_cmd, send_address_cmd_cmd, stwait_cmd, rlwait_cmd, thr_wr, rhr_rd;

  // byte-lane mask from strobes
  genvar gi;
  for (gi = 0; gi < 4; gi++)
  begin : g_lane
    assign wmask[8*gi +: 8] = {8{WSTRB[gi]}};
  end

  assign tick = CLK_EN & BAUD_TICK;

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  assign wr_fire = CLK_EN & AWREADY & WREADY;
  assign rd_fire = CLK_EN & ARREADY;
  assign wr_ok = AWADDR == OFS_CTRL || AWADDR == OFS_MODE || AWADDR == OFS_TXH ||
                 AWADDR == OFS_GUARD || AWADDR == OFS_RTO;
  assign rd_ok = ARADDR == OFS_MODE || ARADDR == OFS_STAT || ARADDR == OFS_RXH ||
                 ARADDR == OFS_GUARD || ARADDR == OFS_RTO;
  // commands act only through the low byte lane
  assign clr_cmd = wr_fire & (AWADDR == OFS_CTRL) & WSTRB[0] & WDATA[CMD_CLR];
  assign send_address_cmd_cmd = wr_fire & (AWADDR == OFS_CTRL) & WSTRB[0] & WDATA[CMD_SEND_ADDRESS_CMD];
  assign stwait_cmd = wr_fire & (AWADDR == OFS_CTRL) & WSTRB[0] & WDATA[CMD_STWAIT];
  assign rlwait_cmd = wr_fire & (AWADDR == OFS_CTRL) & WSTRB[0] & WDATA[CMD_RLWAIT];
  assign thr_wr = wr_fire & (AWADDR == OFS_TXH) & WSTRB[0];
  assign rhr_rd = rd_fire & (ARADDR == OFS_RXH);

  // both address and data must be offered before either is taken
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      AWREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
      WREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
      if (wr_fire)
      begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY)
        BVALID <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      ARREADY <= ARVALID & ~ARREADY & ~RVALID;
      if (rd_fire)
      begin
        RVALID <= 1'b1;
        RDATA <= rd_ok ? rd_mux : 32'h0000_0000;
        RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (RREADY)
        RVALID <= 1'b0;
    end
  end

  // configuration registers, byte-lane merged
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      mode_r <= MODE_RST;
      guard_r <= GUARD_RST;
      rto_r <= RTO_RST;
    end
    else if (wr_fire)
    begin
      if (AWADDR == OFS_MODE)
        mode_r <= (mode_r & ~wmask[3:0]) | (WDATA[3:0] & wmask[3:0]);
      if (AWADDR == OFS_GUARD)
        guard_r <= (guard_r & ~wmask[7:0]) | (WDATA[7:0] & wmask[7:0]);
      if (AWADDR == OFS_RTO)
        rto_r <= (rto_r & ~wmask[15:0]) | (WDATA[15:0] & wmask[15:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity helpers
  logic [PAR_W-1:0] par_sel;
  logic par_on, multi_drop;

  assign par_sel = mode_r[MODE_PAR_LSB +: PAR_W];
  // codes 4 and 5 carry no parity bit
  assign par_on = ~(par_sel[2] & ~par_sel[1]);
  assign multi_drop = par_sel == PAR_MD0 || par_sel == PAR_MD1;

  function automatic logic par_bit(input logic [PAR_W-1:0] sel, input logic ones_odd,
                                   input logic addr);
    logic b;
    b = addr;
    unique case (sel)
      PAR_EVEN: b = ones_odd;
      PAR_ODD: b = ~ones_odd;
      PAR_SPACE: b = 1'b0;
      PAR_MARK: b = 1'b1;
      default: b = addr;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receiver: line passes two flops before anything looks at it
  urpt_rx_e rx_st_r;
  logic [DATA_BITS-1:0] rx_sh_r, rx_hold_r;
  logic [3:0] rx_cnt_r;
  logic rx_pbit_r, rx_done, rx_pe, rx_run;
  logic rx_ready_r, ovr_r, parity_err_flag_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end
    else if (CLK_EN)
    begin
      rxd_m_r <= RXD;
      rxd_s_r <= rxd_m_r;
    end
  end

  // sample only on baud ticks in sync mode
  assign rx_run = tick & mode_r[MODE_SYNC];
  assign rx_done = rx_run & (rx_st_r == RX_STOP);
  assign rx_pe = par_on & (multi_drop ? rx_pbit_r :
                 (rx_pbit_r != par_bit(par_sel, ^rx_sh_r, 1'b0)));

  // start, data lsb first, parity, one stop
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= '0;
      rx_cnt_r <= 4'h0;
      rx_pbit_r <= 1'b0;
    end
    else if (rx_run)
    begin
      unique case (rx_st_r)
        RX_IDLE:
        begin
          rx_cnt_r <= 4'h0;
          if (!rxd_s_r)
            rx_st_r <= RX_DATA;
        end
        RX_DATA:
        begin
          rx_sh_r <= {rxd_s_r, rx_sh_r[DATA_BITS-1:1]};
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == 4'(DATA_BITS - 1))
            rx_st_r <= par_on ? RX_PAR : RX_STOP;
        end
        RX_PAR:
        begin
          rx_pbit_r <= rxd_s_r;
          rx_st_r <= RX_STOP;
        end
        RX_STOP: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // status flags: a new event wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      rx_hold_r <= '0;
      rx_ready_r <= 1'b0;
      ovr_r <= 1'b0;
      parity_err_flag_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (rx_done)
        rx_hold_r <= rx_sh_r;
      rx_ready_r <= rx_done | (rx_ready_r & ~rhr_rd);
      ovr_r <= (rx_done & rx_ready_r) | (ovr_r & ~clr_cmd);
      parity_err_flag_r <= (rx_done & rx_pe) | (parity_err_flag_r & ~clr_cmd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle time-out counter, one decrement per bit period
  logic [TOUT_W-1:0] tout_cnt_r;
  logic tout_run_r, tout_rl_r, tout_r, tout_hit, tout_cmd;

  assign tout_cmd = stwait_cmd | rlwait_cmd;
  assign tout_hit = tick & tout_run_r & ~tout_cmd & ~rx_done & (tout_cnt_r == 16'h0001);

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      tout_cnt_r <= 16'h0000;
      tout_run_r <= 1'b0;
      tout_rl_r <= 1'b0;
    end
    else if (tout_cmd)
    begin
      tout_cnt_r <= rto_r;
      tout_run_r <= rlwait_cmd;
      tout_rl_r <= rlwait_cmd;
    end
    else if (rx_done)
    begin
      tout_cnt_r <= rto_r;
      tout_run_r <= 1'b1;
    end
    else if (tick & tout_run_r & (tout_cnt_r != 16'h0000))
    begin
      // periodic reload only in reload-wait mode
      tout_cnt_r <= (tout_hit & tout_rl_r) ? rto_r : tout_cnt_r - 16'h0001;
      if (tout_hit & ~tout_rl_r)
        tout_run_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
      tout_r <= 1'b0;
    else if (CLK_EN)
      // disabled value forces low, commands clear
      tout_r <= (rto_r != 16'h0000) & (tout_hit | (tout_r & ~tout_cmd));
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter with holding register and timeguard
  urpt_tx_e tx_st_r;
  logic [DATA_BITS-1:0] tx_hold_r, tx_sh_r;
  logic tx_hold_v_r, tx_hold_a_r, send_address_cmd_pend_r, tx_par_r;
  logic [3:0] tx_cnt_r;
  logic [GUARD_W-1:0] tx_gcnt_r;
  logic tx_char_end, tx_load, tx_ready, tx_empty;

  // zero guard ends the character at stop
  assign tx_char_end = tick & ((tx_st_r == TX_STOP && guard_r == 8'h00) ||
                               (tx_st_r == TX_GUARD && tx_gcnt_r == 8'h01));
  assign tx_load = tx_hold_v_r & ((tick & tx_st_r == TX_IDLE) | tx_char_end);
  // ready only once the holding byte moves to the shifter
  assign tx_ready = ~tx_hold_v_r;
  // guard counts as part of the character
  assign tx_empty = (tx_st_r == TX_IDLE) & ~tx_hold_v_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      tx_hold_r <= '0;
      tx_hold_v_r <= 1'b0;
      tx_hold_a_r <= 1'b0;
      send_address_cmd_pend_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // writes while full are dropped
      if (thr_wr & tx_hold_v_r == 1'b0)
      begin
        tx_hold_r <= WDATA[DATA_BITS-1:0];
        tx_hold_v_r <= 1'b1;
        // address mark follows the send-address command
        tx_hold_a_r <= send_address_cmd_pend_r | send_address_cmd_cmd;
        send_address_cmd_pend_r <= 1'b0;
      end
      else
      begin
        if (tx_load)
          tx_hold_v_r <= 1'b0;
        if (send_address_cmd_cmd)
          send_address_cmd_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= '0;
      tx_par_r <= 1'b0;
      tx_cnt_r <= 4'h0;
      tx_gcnt_r <= 8'h00;
      TXD <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_sh_r <= tx_hold_r;
      tx_par_r <= par_bit(par_sel, ^tx_hold_r, tx_hold_a_r);
      tx_st_r <= TX_START;
      TXD <= 1'b0;
    end
    else if (tick)
    begin
      unique case (tx_st_r)
        TX_IDLE: TXD <= 1'b1;
        TX_START, TX_DATA:
        begin
          if (tx_st_r == TX_DATA && tx_cnt_r == 4'(DATA_BITS))
          begin
            TXD <= par_on ? tx_par_r : 1'b1;
            tx_st_r <= par_on ? TX_PAR : TX_STOP;
          end
          else
          begin
            TXD <= tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
            tx_cnt_r <= (tx_st_r == TX_START) ? 4'h1 : tx_cnt_r + 4'h1;
            tx_st_r <= TX_DATA;
          end
        end
        TX_PAR:
        begin
          TXD <= 1'b1;
          tx_st_r <= TX_STOP;
        end
        TX_STOP:
        begin
          // hold line high for guard bits
          tx_gcnt_r <= guard_r;
          tx_st_r <= (guard_r == 8'h00) ? TX_IDLE : TX_GUARD;
        end
        TX_GUARD:
        begin
          tx_gcnt_r <= tx_gcnt_r - 8'h01;
          if (tx_gcnt_r == 8'h01)
            tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  // read-back selection
  assign rd_mux = (ARADDR == OFS_MODE) ? {28'h0, mode_r} :
                  (ARADDR == OFS_STAT) ? {26'h0, tout_r, parity_err_flag_r, ovr_r, tx_empty,
                                          tx_ready, rx_ready_r} :
                  (ARADDR == OFS_RXH) ? {{(32-DATA_BITS){1'b0}}, rx_hold_r} :
                  (ARADDR == OFS_GUARD) ? {24'h0, guard_r} : {16'h0, rto_r};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  AST_SYNC_START: assert property (rx_run && rx_st_r == RX_IDLE && !rxd_s_r |=>
    rx_st_r == RX_DATA) else $error("start bit not taken");
  AST_RX_LOAD: assert property (rx_done |=> rx_ready_r &&
    rx_hold_r == $past(rx_sh_r)) else $error("character not held");
  AST_OVERRUN: assert property (rx_done && rx_ready_r |=> ovr_r)
    else $error("overrun missed");
  AST_CLEAR: assert property (clr_cmd && !rx_done |=> !ovr_r && !parity_err_flag_r)
    else $error("clear-status failed");
  AST_PARITY_ERR_FLAG: assert property (rx_done && rx_pe |=> parity_err_flag_r)
    else $error("parity error missed");
  AST_NO_PARITY: assert property (CLK_EN && !par_on && !parity_err_flag_r |=> !parity_err_flag_r)
    else $error("parity error without parity");
  AST_GUARD_HIGH: assert property (tx_st_r == TX_GUARD |-> TXD && !tx_empty)
    else $error("guard not idle high");
  AST_GUARD_READY: assert property (tx_st_r == TX_GUARD && tx_hold_v_r && !tx_char_end |=>
    !tx_ready) else $error("ready rose in guard");
  AST_TOUT_OFF: assert property (rto_r == 16'h0000 && $past(rto_r) == 16'h0000 |->
    !tout_r) else $error("time-out while disabled");
  AST_WAIT_FROZEN: assert property (!tout_run_r && !tout_cmd && !rx_done |=>
    $stable(tout_cnt_r)) else $error("counter moved while frozen");

  COV_OVERRUN: cover property (rx_done && rx_ready_r);
  COV_PARITY_ERR_FLAG: cover property (rx_done && rx_pe);
  COV_GUARD: cover property (tx_st_r == TX_GUARD ##1 tx_st_r == TX_START);
  COV_TOUT: cover property (tout_hit);
endmodule

// file: tb/tb.sv
// self-checking bench for the synchronous serial channel and its register bus
`timescale 1ns/1ps
module tb;
  import urpt_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic BAUD_TICK = 1'b0;
  logic CLK_EN = 1'b1;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hf;
  logic RXD, TXD, AWREADY, WREADY, BVALID, ARREADY, RVALID, send_busy;
  logic [1:0] BRESP, RRESP, wr_resp, rd_resp;
  logic [31:0] RDATA, rd_data;
  logic send_go = 1'b0;
  logic [10:0] send_bits = 11'h7ff;
  logic [3:0] send_len = 4'h0;
  logic [8:0] frame_r;
  logic [7:0] gap_r, frames_r, want_frames;
  logic [1:0] tcnt = 2'h0;
  logic [2:0] modes [7] = '{PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK, PAR_NONE, PAR_MD0, PAR_MD1};
  int err_count = 0;
  int comparisons = 0;

  // 40 ns clock; bit period of four clocks leaves room for the two-flop input sync
  always #20 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
  begin
    tcnt <= tcnt + 2'h1;
    BAUD_TICK <= (tcnt == 2'h3);
  end

  urpt_top u_urpt_top (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN), .BAUD_TICK(BAUD_TICK),
    .RXD(RXD), .TXD(TXD), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  // the remote sees the same gated bit clock as the channel
  urpt_remote u_urpt_remote (.sys_clk(SYS_CLK), .rst_b(RST_B), .baud_tick(BAUD_TICK & CLK_EN),
    .txd(TXD), .send_go(send_go), .send_bits(send_bits), .send_len(send_len), .rxd(RXD),
    .send_busy(send_busy), .frame_r(frame_r), .gap_r(gap_r), .frames_r(frames_r));

  ////////////////////////////////////////
  // verdict and comparisons
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_data({30'h0, got}, {30'h0, exp});
  endtask
  // waited conditions; sampled at the falling edge where everything has settled
  function automatic logic pick(input int s);
    case (s)
      0: pick = AWREADY & WREADY;
      1: pick = BVALID;
      2: pick = ARREADY;
      3: pick = RVALID;
      4: pick = !send_busy;
      5: pick = (frames_r === want_frames);
      default: pick = !TXD;
    endcase
  endfunction
  task automatic wait_for(input int s);
    int n;
    n = 0;
    @(negedge SYS_CLK);
    while (pick(s) !== 1'b1 && n <= 3000)
    begin
      n++;
      @(negedge SYS_CLK);
    end
    // a wait that runs out ends the run as a mismatch
    if (n > 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // bus master: valid held until the ready edge, response ready until valid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    wait_for(0);
    @(posedge SYS_CLK);
    AWVALID <= 1'b0;
    WVALID <= 1'b0;
    wait_for(1);
    wr_resp = BRESP;
    @(posedge SYS_CLK);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    wait_for(2);
    @(posedge SYS_CLK);
    ARVALID <= 1'b0;
    wait_for(3);
    rd_data = RDATA;
    rd_resp = RRESP;
    @(posedge SYS_CLK);
    RREADY <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk_data(rd_data, e);
  endtask
  // expected parity bit of a byte for a parity code
  function automatic logic epar(input logic [2:0] m, input logic [7:0] d);
    case (m)
      PAR_EVEN: epar = ^d;
      PAR_ODD: epar = ~^d;
      PAR_MARK: epar = 1'b1;
      default: epar = 1'b0;
    endcase
  endfunction
  // remote sends one character; flags settle a tick after its stop bit
  task automatic rx_char(input logic [7:0] d, input logic p, input logic [3:0] n);
    @(posedge SYS_CLK);
    send_bits <= {1'b1, p, d, 1'b0};
    send_len <= n;
    send_go <= 1'b1;
    @(posedge SYS_CLK);
    send_go <= 1'b0;
    wait_for(4);
    repeat (8) @(posedge SYS_CLK);
  endtask
  task automatic tx_byte(input logic [7:0] d);
    want_frames = frames_r + 8'h01;
    wr(OFS_TXH, {24'h0, d});
    wait_for(5);
  endtask

  ////////////////////////////////////////
  // scenarios
  task automatic s_reset();
    rd_chk(OFS_MODE, {28'h0, MODE_RST});
    rd_chk(OFS_GUARD, {24'h0, GUARD_RST});
    rd_chk(OFS_RTO, {16'h0, RTO_RST});
    rd_chk(OFS_STAT, 32'h6);
    rd_chk(8'h1c, 32'h0);
    chk_resp(rd_resp, RESP_SLVERR);
    rd(OFS_CTRL);
    chk_resp(rd_resp, RESP_SLVERR);
    wr(OFS_STAT, 32'h0);
    chk_resp(wr_resp, RESP_SLVERR);
  endtask
  task automatic s_rx();
    logic p;
    logic [7:0] d;
    logic [3:0] n;
    for (int i = 0; i < 7; i++)
    begin
      d = 8'h41 + 8'(i);
      p = epar(modes[i], d);
      n = (modes[i] == PAR_NONE) ? 4'ha : 4'hb;
      wr(OFS_MODE, {28'h0, modes[i], 1'b1});
      chk_resp(wr_resp, RESP_OKAY);
      rx_char(d, p, n);
      rd_chk(OFS_RXH, {24'h0, d});
      rd_chk(OFS_STAT, 32'h6);
      rx_char(d, ~p, n);
      rd_chk(OFS_STAT, (modes[i] == PAR_NONE) ? 32'h7 : 32'h17);
      wr(OFS_CTRL, 32'h1);
      rd_chk(OFS_STAT, 32'h7);
      rd(OFS_RXH);
    end
  endtask
  task automatic s_ovr();
    wr(OFS_MODE, 32'h0);
    rx_char(8'h3c, 1'b0, 4'hb);
    rd_chk(OFS_STAT, 32'h6);
    wr(OFS_MODE, 32'h1);
    rx_char(8'h3c, 1'b0, 4'hb);
    rx_char(8'hc3, 1'b0, 4'hb);
    rd_chk(OFS_STAT, 32'hf);
    rd_chk(OFS_RXH, 32'hc3);
    wr(OFS_CTRL, 32'h1);
    rd_chk(OFS_STAT, 32'h6);
  endtask
  task automatic s_tx();
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS_MODE, {28'h0, modes[i], 1'b1});
      tx_byte(8'h43);
      // parity none shows the stop bit in the ninth place
      chk_data({23'h0, frame_r},
        {23'h0, (modes[i] == PAR_NONE) | epar(modes[i], 8'h43), 8'h43});
    end
    wr(OFS_CTRL, 32'h2);
    tx_byte(8'h43);
    chk_data({23'h0, frame_r}, 32'h143);
    tx_byte(8'h43);
    chk_data({23'h0, frame_r}, 32'h043);
  endtask
  task automatic s_tout();
    wr(OFS_MODE, 32'h1);
    wr(OFS_CTRL, 32'h8);
    repeat (60) @(posedge SYS_CLK);
    rd_chk(OFS_STAT, 32'h6);
    wr(OFS_RTO, 32'h5);
    wr(OFS_CTRL, 32'h8);
    repeat (40) @(posedge SYS_CLK);
    rd_chk(OFS_STAT, 32'h26);
    wr(OFS_CTRL, 32'h4);
    rd_chk(OFS_STAT, 32'h6);
    repeat (60) @(posedge SYS_CLK);
    rd_chk(OFS_STAT, 32'h6);
    rx_char(8'h3c, 1'b0, 4'hb);
    repeat (40) @(posedge SYS_CLK);
    rd_chk(OFS_STAT, 32'h27);
    rd(OFS_RXH);
    wr(OFS_RTO, 32'h0);
    wr(OFS_CTRL, 32'h4);
  endtask
  // second byte written while the first is on the line, so the gap is stop plus guard
  task automatic guard_run(input logic [7:0] g);
    wr(OFS_GUARD, {24'h0, g});
    want_frames = frames_r + 8'h01;
    wr(OFS_TXH, 32'h5a);
    wait_for(6);
    wr(OFS_TXH, 32'ha5);
    wait_for(5);
    if (g != 8'h00)
      rd_chk(OFS_STAT, 32'h0);
    want_frames = want_frames + 8'h01;
    wait_for(5);
    chk_data({24'h0, gap_r}, {24'h0, g} + 32'h1);
  endtask
  task automatic s_guard();
    wr(OFS_GUARD, 32'h1ff);
    rd_chk(OFS_GUARD, 32'hff);
    guard_run(8'h03);
    repeat (40) @(posedge SYS_CLK);
    rd_chk(OFS_STAT, 32'h6);
    guard_run(8'h00);
  endtask
  // a low clock enable must hold the line mid-character and lose no bit
  task automatic s_freeze();
    want_frames = frames_r + 8'h01;
    wr(OFS_TXH, 32'h43);
    wait_for(6);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    repeat (100) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk_data({31'h0, TXD}, 32'h0);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    wait_for(5);
    chk_data({23'h0, frame_r}, {23'h0, epar(PAR_EVEN, 8'h43), 8'h43});
  endtask

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    s_reset();
    s_rx();
    s_ovr();
    s_tx();
    s_tout();
    s_guard();
    s_freeze();
    tally_and_finish();
  end
endmodule

// file: tb/urpt_remote.sv
// remote serial device model: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
module urpt_remote (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic baud_tick,
  input wire logic txd,
  input wire logic send_go,
  input wire logic [10:0] send_bits,
  input wire logic [3:0] send_len,
  output logic rxd,
  output logic send_busy,
  output logic [8:0] frame_r,
  output logic [7:0] gap_r,
  output logic [7:0] frames_r
);
  logic [10:0] sh_r;
  logic [3:0] scnt_r;
  logic [3:0] rcnt_r;
  logic [7:0] ones_r;

  // line idles high before the first reset edge
  initial rxd = 1'b1;

  ////////////////////////////////////////
  // outbound character, start bit first, one bit per tick; line returns high once all bits are out
  // start low then bits
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rxd <= 1'b1;
      send_busy <= 1'b0;
      scnt_r <= 4'h0;
    end
    else if (send_go)
    begin
      sh_r <= send_bits;
      scnt_r <= send_len;
      send_busy <= 1'b1;
    end
    else if (baud_tick && send_busy)
    begin
      if (scnt_r == 4'h0)
      begin
        // released line goes back to its idle level, not the last bit sent
        rxd <= 1'b1;
        send_busy <= 1'b0;
      end
      else
      begin
        rxd <= sh_r[0];
        sh_r <= sh_r >> 1;
        scnt_r <= scnt_r - 4'h1;
      end
    end
  end

  ////////////////////////////////////////
  // inbound: nine bits after a start; guard ticks, and the stop tick when parity is on, count as idle ones
  // parity and gap capture
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rcnt_r <= 4'h0;
      ones_r <= 8'h00;
      gap_r <= 8'h00;
      frames_r <= 8'h00;
      frame_r <= 9'h000;
    end
    else if (baud_tick)
    begin
      if (rcnt_r != 4'h0)
      begin
        frame_r <= {txd, frame_r[8:1]};
        rcnt_r <= rcnt_r - 4'h1;
        frames_r <= frames_r + {7'h00, rcnt_r == 4'h1};
      end
      else if (!txd)
      begin
        rcnt_r <= 4'h9;
        gap_r <= ones_r;
        ones_r <= 8'h00;
      end
      else
        ones_r <= ones_r + 8'h01; // wraps on long idle, first gap is ignored
    end
  end
endmodule
